/* core/eth_bd_logic.sv */
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ns
// Behaviour
// [RULE1] Closing receive buffer clears empty, writes fields
// [RULE2] Frame error flags written only in last
// [RULE3] Wrap flag returns to table start
// [RULE4] Interrupt flag raises buffer event
// [RULE5] First and last flags mark true ends
// [RULE6] Miss set for unmatched frames taken anyway
// [RULE7] Store at most 1520 bytes, flag oversize
// [RULE8] Odd bit count with bad check: partial
// [RULE9] Whole octets with bad check: checksum fail
// [RULE10] Overflow sets spill, zeroes other flags
// [RULE11] Late collision sets flag, closes frame
// [RULE12] Length word holds stored octet count
// [RULE13] Tag enable puts index in pointer
// [RULE14] Software gives even external buffer addresses
// [RULE15] Ownership bits and unused bits untouched
// [RULE16] Ready cleared after send; software waits
// [RULE17] Middle buffers freed on fetch, last later
// [RULE18] Append checksum only when requested
// [RULE19] Deferred flag unless a collision happened
// [RULE20] Heartbeat error only when check enabled
// [RULE21] Late collision and lost carrier flags
// [RULE22] Four bit retry count and limit flag
// [RULE23] Underrun: bad checksum, discard rest, flag
// [RULE24] Tag carries line number or hash index
module eth_bd_logic #(
	parameter int unsigned TX_DESC    = 8,
	parameter int unsigned RX_DESC    = 120,
	parameter int unsigned RX_BUF_MAX = 128
) (
	input  wire logic                         CLK_IN,
	input  wire logic                         RST_N_IN,
	input  wire logic                         WB_CYC_IN,
	input  wire logic                         WB_STB_IN,
	input  wire logic                         WB_WE_IN,
	input  wire logic [eth_bd_pkg::ADR_W-1:0] WB_ADR_IN,
	input  wire logic [3:0]                   WB_SEL_IN,
	input  wire logic [31:0]                  WB_DAT_IN,
	output logic      [31:0]                  WB_DAT_OUT,
	output logic                              WB_ACK_OUT,
	input  wire logic                         RX_BYTE_VALID_IN,
	input  wire logic [7:0]                   RX_BYTE_IN,
	input  wire logic                         RX_EOF_IN,
	input  wire logic                         RX_LATE_COLL_IN,
	input  wire logic                         RX_ODD_BITS_IN,
	input  wire logic                         RX_CRC_BAD_IN,
	input  wire logic                         RX_OVERRUN_IN,
	input  wire logic                         RX_MATCHED_IN,
	input  wire logic [7:0]                   RX_MATCH_INDEX_IN,
	output logic                              RX_WR_OUT,
	output logic      [31:0]                  RX_WR_ADDR_OUT,
	output logic      [7:0]                   RX_WR_DATA_OUT,
	output logic                              TX_REQ_OUT,
	output logic      [23:0]                  TX_ADDR_OUT,
	output logic      [15:0]                  TX_LEN_OUT,
	output logic                              TX_LAST_OUT,
	output logic                              TX_APPEND_CRC_OUT,
	output logic                              TX_BAD_CRC_OUT,
	input  wire logic                         TX_FETCHED_IN,
	input  wire logic                         TX_UNDERRUN_IN,
	input  wire logic                         TX_DONE_IN,
	input  wire logic                         TX_DEFERRED_IN,
	input  wire logic                         TX_COLLIDED_IN,
	input  wire logic                         TX_HEARTBEAT_IN,
	input  wire logic                         TX_LATE_COLL_IN,
	input  wire logic                         TX_RETRY_LIMIT_IN,
	input  wire logic [3:0]                   TX_RETRIES_IN,
	input  wire logic                         TX_CARRIER_LOST_IN
);
	import eth_bd_pkg::*;

	// ----------------------------------------------------------------
	// Sizes and address helpers
	// ----------------------------------------------------------------
	localparam int unsigned TXW       = $clog2(TX_DESC);
	localparam int unsigned RXW       = $clog2(RX_DESC);
	localparam int unsigned MEM_WORDS = (TX_DESC + RX_DESC) * 4;
	localparam int unsigned MW        = $clog2(MEM_WORDS);

	// Transmit descriptors sit first, receive ones right after them.
	function automatic logic [MW-1:0] tx_word(input logic [TXW-1:0] i,
	                                          input logic [1:0]     w);
		return MW'({i, w});
	endfunction

	function automatic logic [MW-1:0] rx_word(input logic [RXW-1:0] i,
	                                          input logic [1:0]     w);
		return MW'({i, w}) + MW'(TX_DESC * 4);
	endfunction

	function automatic logic is_desc(input logic [ADR_W-1:0] a);
		return (a >= DESC_OFS) &&
		       ((a - DESC_OFS) < ADR_W'(MEM_WORDS * 4));
	endfunction

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	logic [15:0]    desc_mem [0:MEM_WORDS-1];
	logic [3:0]     ctrl_reg;
	logic [1:0]     ev_reg;
	logic [1:0]     ev_next;
	logic           ack_reg;
	logic [31:0]    rdat_reg;
	logic [31:0]    rd_mux;
	logic [RXW-1:0] rx_idx_reg;
	logic           rx_open_reg;
	logic           rx_first_reg;
	logic           rx_big_reg;
	logic           rx_spill_reg;
	logic [10:0]    rx_flen_reg;
	logic [15:0]    rx_cnt_reg;
	logic [31:0]    rx_base_reg;
	logic [TXW-1:0] tx_idx_reg;
	logic           tx_starve_reg;
	tx_state_type   tx_state_reg;

	logic           en;
	logic           bus_wr;
	logic [MW-1:0]  bus_word;
	logic [MW-1:0]  rx_a0;
	logic [MW-1:0]  tx_a0;
	logic [15:0]    rx_w0;
	logic [15:0]    tx_w0;
	logic [31:0]    rx_base_cur;
	logic [15:0]    rx_cnt_inc;
	logic           rx_avail;
	logic           rx_store;
	logic           rx_fin;
	logic           rx_end;
	logic           rx_close;
	logic [15:0]    rx_len;
	logic           rx_spill_all;
	logic           rx_big_all;
	logic [RXW-1:0] rx_idx_next;
	logic [15:0]    rx_st;
	logic           tx_rel;
	logic           tx_full_st;
	logic [TXW-1:0] tx_idx_next;
	logic [15:0]    tx_st;

	assign en       = ctrl_reg[CTRL_EN_BIT];
	assign bus_wr   = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ack_reg;
	assign bus_word = MW'((WB_ADR_IN - DESC_OFS) >> 2);
	assign rx_a0    = rx_word(rx_idx_reg, W_STAT);
	assign tx_a0    = tx_word(tx_idx_reg, W_STAT);
	assign rx_w0    = desc_mem[rx_a0];
	assign tx_w0    = desc_mem[tx_a0];

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Ack comes one cycle after the strobe; writes land on the edge
	// where the master sees ack, so a write never lands twice.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			ack_reg  <= 1'h0;
			rdat_reg <= 32'h0;
		end else begin
			ack_reg  <= WB_CYC_IN & WB_STB_IN & !ack_reg;
			rdat_reg <= rd_mux;
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rd_mux = 32'h0;
		if (is_desc(WB_ADR_IN)) begin
			rd_mux[15:0] = desc_mem[bus_word];
		end else if (WB_ADR_IN == CTRL_OFS) begin
			rd_mux[3:0] = ctrl_reg;
		end else if (WB_ADR_IN == EVENT_OFS) begin
			rd_mux[1:0] = ev_reg;
		end else if (WB_ADR_IN == STATE_OFS) begin
			rd_mux[RXW-1:0]            = rx_idx_reg;
			rd_mux[ST_TXIDX_LSB+:TXW]  = tx_idx_reg;
			rd_mux[ST_OPEN_BIT]        = rx_open_reg;
			rd_mux[ST_STARVE_BIT]      = tx_starve_reg;
		end
	end

	assign WB_ACK_OUT = ack_reg;
	assign WB_DAT_OUT = rdat_reg;

	// Control register.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			ctrl_reg <= CTRL_RESET;
		end else if (bus_wr && WB_ADR_IN == CTRL_OFS && WB_SEL_IN[0]) begin
			ctrl_reg <= WB_DAT_IN[3:0];
		end
	end

	// Sticky events, cleared by writing one; a new event wins.
	always_comb begin
		ev_next = ev_reg;
		if (bus_wr && WB_ADR_IN == EVENT_OFS && WB_SEL_IN[0]) begin
			ev_next = ev_reg & ~WB_DAT_IN[1:0];
		end
		if (rx_close && rx_w0[D_INT]) begin // RULE4
			ev_next[EV_RX_BIT] = 1'h1;
		end
		if (tx_rel && tx_w0[D_INT]) begin // RULE4
			ev_next[EV_TX_BIT] = 1'h1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			ev_reg <= 2'h0;
		end else begin
			ev_reg <= ev_next;
		end
	end

	// ----------------------------------------------------------------
	// Receive descriptor handling
	// ----------------------------------------------------------------
	// Buffer base is software's even pointer; bytes go out one by one.
	assign rx_base_cur  = rx_open_reg ? rx_base_reg : // RULE14
	                      {desc_mem[rx_word(rx_idx_reg, W_PHI)],
	                       desc_mem[rx_word(rx_idx_reg, W_PLO)]};
	assign rx_cnt_inc   = rx_cnt_reg + 16'h1;
	assign rx_avail     = rx_open_reg | rx_w0[D_OWN];
	assign rx_store     = RX_BYTE_VALID_IN & en & rx_avail &
	                      (rx_flen_reg < RX_FRAME_MAX); // RULE7
	assign rx_fin       = en & (RX_EOF_IN | RX_LATE_COLL_IN); // RULE11
	assign rx_end       = rx_fin & rx_avail;
	assign rx_close     = rx_end |
	                      (rx_store && rx_cnt_inc == 16'(RX_BUF_MAX));
	assign rx_len       = rx_store ? rx_cnt_inc : rx_cnt_reg; // RULE12
	assign rx_spill_all = rx_spill_reg | RX_OVERRUN_IN |
	                      (RX_BYTE_VALID_IN & !rx_avail);
	assign rx_big_all   = rx_big_reg |
	                      (RX_BYTE_VALID_IN & !rx_store & rx_avail);
	assign rx_idx_next  = (rx_w0[D_WRAP] || // RULE3
	                       rx_idx_reg == RXW'(RX_DESC - 1)) ?
	                      RXW'(0) : RXW'(rx_idx_reg + 1'h1);

	// Status word for the buffer being closed; frame flags only on last.
	always_comb begin
		rx_st           = rx_w0;
		rx_st[D_OWN]    = 1'h0; // RULE1
		rx_st[D_LAST]   = rx_end; // RULE5
		rx_st[RX_FIRST] = rx_first_reg; // RULE5
		if (rx_end) begin // RULE2
			rx_st        = rx_st & ~RX_ERR_MASK;
			rx_st[RX_OV] = rx_spill_all; // RULE10
			if (!rx_spill_all) begin
				rx_st[RX_MISS] = ctrl_reg[CTRL_ALL_BIT] & // RULE6
				                 !RX_MATCHED_IN;
				rx_st[RX_LG]   = rx_big_all; // RULE7
				rx_st[RX_NO]   = RX_ODD_BITS_IN & RX_CRC_BAD_IN; // RULE8
				rx_st[RX_CR]   = !RX_ODD_BITS_IN & RX_CRC_BAD_IN; // RULE9
				rx_st[RX_CL]   = RX_LATE_COLL_IN; // RULE11
			end
		end
	end

	// Frame and buffer bookkeeping; a frame with no free buffer at its
	// end is lost without trace, as no descriptor is there to tell.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN || !en) begin
			rx_idx_reg     <= RXW'(0);
			rx_open_reg    <= 1'h0;
			rx_first_reg   <= 1'h1;
			rx_cnt_reg     <= 16'h0;
			rx_base_reg    <= 32'h0;
			RX_WR_OUT      <= 1'h0;
			RX_WR_ADDR_OUT <= 32'h0;
			RX_WR_DATA_OUT <= 8'h0;
		end else begin
			RX_WR_OUT      <= rx_store;
			RX_WR_ADDR_OUT <= rx_base_cur + 32'(rx_cnt_reg);
			RX_WR_DATA_OUT <= RX_BYTE_IN;
			if (rx_close) begin
				rx_open_reg  <= 1'h0;
				rx_cnt_reg   <= 16'h0;
				rx_idx_reg   <= rx_idx_next;
				rx_first_reg <= rx_end; // RULE5
			end else if (rx_store) begin
				rx_open_reg <= 1'h1;
				rx_cnt_reg  <= rx_cnt_inc;
				rx_base_reg <= rx_base_cur;
			end
		end
	end

	// Per-frame length and error history.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN || !en || rx_fin) begin
			rx_flen_reg  <= 11'h0;
			rx_big_reg   <= 1'h0;
			rx_spill_reg <= 1'h0;
		end else begin
			rx_big_reg   <= rx_big_all;
			rx_spill_reg <= rx_spill_all;
			if (rx_store) begin
				rx_flen_reg <= rx_flen_reg + 11'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit descriptor handling
	// ----------------------------------------------------------------
	assign tx_idx_next = (tx_w0[D_WRAP] || // RULE3
	                      tx_idx_reg == TXW'(TX_DESC - 1)) ?
	                     TXW'(0) : TXW'(tx_idx_reg + 1'h1);

	// Release decision and status word for the current descriptor.
	always_comb begin
		tx_rel     = 1'h0;
		tx_full_st = 1'h0;
		unique case (tx_state_reg)
			TX_IDLE: begin
				tx_rel     = en & tx_w0[D_OWN] & tx_starve_reg; // RULE23
				tx_full_st = tx_w0[D_LAST];
			end
			TX_FETCH: begin
				tx_rel = TX_FETCHED_IN & !tx_w0[D_LAST]; // RULE17
			end
			TX_WAIT: begin
				tx_rel     = TX_DONE_IN; // RULE17
				tx_full_st = 1'h1;
			end
		endcase
		tx_st        = tx_w0; // RULE15
		tx_st[D_OWN] = 1'h0; // RULE16
		if (tx_full_st) begin
			tx_st[TX_DEF] = (tx_state_reg == TX_WAIT) & // RULE19
			                TX_DEFERRED_IN & !TX_COLLIDED_IN;
			tx_st[TX_HB]  = (tx_state_reg == TX_WAIT) & // RULE20
			                !TX_HEARTBEAT_IN & !ctrl_reg[CTRL_HBOFF_BIT];
			tx_st[TX_LC]  = (tx_state_reg == TX_WAIT) & // RULE21
			                TX_LATE_COLL_IN;
			tx_st[TX_RL]  = (tx_state_reg == TX_WAIT) & // RULE22
			                TX_RETRY_LIMIT_IN;
			tx_st[TX_RC_LSB+:4] = (tx_state_reg == TX_WAIT) ? // RULE22
			                      TX_RETRIES_IN : 4'h0;
			tx_st[TX_UN]  = tx_starve_reg | TX_UNDERRUN_IN; // RULE23
			tx_st[TX_CSL] = (tx_state_reg == TX_WAIT) & // RULE21
			                TX_CARRIER_LOST_IN & !TX_COLLIDED_IN;
		end
	end

	// Fetch sequencer: offer a ready buffer, wait for its fetch, and
	// for the last buffer wait for the frame outcome as well.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN || !en) begin
			tx_state_reg      <= TX_IDLE;
			tx_idx_reg        <= TXW'(0);
			TX_REQ_OUT        <= 1'h0;
			TX_ADDR_OUT       <= 24'h0;
			TX_LEN_OUT        <= 16'h0;
			TX_LAST_OUT       <= 1'h0;
			TX_APPEND_CRC_OUT <= 1'h0;
		end else begin
			if (tx_rel) begin
				tx_idx_reg <= tx_idx_next;
			end
			unique case (tx_state_reg)
				TX_IDLE: begin
					if (tx_w0[D_OWN] && !tx_starve_reg) begin
						TX_REQ_OUT        <= 1'h1;
						TX_ADDR_OUT       <= {desc_mem[tx_word(tx_idx_reg,
						                       W_PHI)][7:0],
						                      desc_mem[tx_word(tx_idx_reg,
						                       W_PLO)]};
						TX_LEN_OUT        <= desc_mem[tx_word(tx_idx_reg,
						                      W_LEN)];
						TX_LAST_OUT       <= tx_w0[D_LAST];
						TX_APPEND_CRC_OUT <= tx_w0[D_LAST] & // RULE18
						                     tx_w0[TX_TC];
						tx_state_reg      <= TX_FETCH;
					end
				end
				TX_FETCH: begin
					if (TX_FETCHED_IN) begin
						TX_REQ_OUT   <= 1'h0;
						tx_state_reg <= tx_w0[D_LAST] ? TX_WAIT : TX_IDLE;
					end
				end
				TX_WAIT: begin
					if (TX_DONE_IN) begin
						tx_state_reg <= TX_IDLE;
					end
				end
			endcase
		end
	end

	// Underrun state: forces a bad checksum and discards the rest of
	// the frame. An underrun that meets the last release is already
	// recorded in that descriptor, so the clear may follow it.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN || !en) begin
			tx_starve_reg <= 1'h0;
		end else if (tx_rel && tx_w0[D_LAST]) begin
			tx_starve_reg <= 1'h0;
		end else if (TX_UNDERRUN_IN) begin // RULE23
			tx_starve_reg <= 1'h1;
		end
	end

	assign TX_BAD_CRC_OUT = tx_starve_reg; // RULE23

	// ----------------------------------------------------------------
	// Descriptor memory
	// ----------------------------------------------------------------
	// Hardware writes come last so they win over a stray bus write.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			for (int k = 0; k < MEM_WORDS; k++) begin
				desc_mem[k] <= 16'h0;
			end
		end else begin
			if (bus_wr && is_desc(WB_ADR_IN)) begin
				if (WB_SEL_IN[0]) begin
					desc_mem[bus_word][7:0] <= WB_DAT_IN[7:0];
				end
				if (WB_SEL_IN[1]) begin
					desc_mem[bus_word][15:8] <= WB_DAT_IN[15:8];
				end
			end
			if (rx_close) begin
				desc_mem[rx_a0] <= rx_st; // RULE1
				desc_mem[rx_word(rx_idx_reg, W_LEN)] <= rx_len; // RULE12
				if (ctrl_reg[CTRL_TAG_BIT]) begin // RULE13 RULE24
					desc_mem[rx_word(rx_idx_reg, W_PHI)][15:8] <=
					    RX_MATCH_INDEX_IN;
				end
			end
			if (tx_rel) begin
				desc_mem[tx_a0] <= tx_st; // RULE16
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	rx_own_clear_a: assert property ( // RULE1
		rx_close |=> !desc_mem[$past(rx_a0)][D_OWN])
		else $error("closed receive buffer still empty");
	rx_err_keep_a: assert property ( // RULE2
		rx_close && !rx_end |=>
		(desc_mem[$past(rx_a0)] & RX_ERR_MASK) ==
		($past(rx_w0) & RX_ERR_MASK))
		else $error("error flags changed on middle buffer");
	rx_wrap_a: assert property ( // RULE3
		en && rx_close && rx_w0[D_WRAP] |=> rx_idx_reg == RXW'(0))
		else $error("receive wrap ignored");
	rx_event_a: assert property ( // RULE4
		rx_close && rx_w0[D_INT] |=> ev_reg[EV_RX_BIT])
		else $error("receive buffer event missing");
	rx_len_cap_a: assert property ( // RULE7
		RX_WR_OUT |-> $past(rx_flen_reg) < RX_FRAME_MAX)
		else $error("byte stored past frame limit");
	rx_spill_a: assert property ( // RULE10
		rx_end && rx_spill_all |=>
		(desc_mem[$past(rx_a0)] & RX_ERR_MASK) == 16'h0002)
		else $error("spill did not clear other flags");
	tx_mid_free_a: assert property ( // RULE17
		tx_state_reg == TX_FETCH && TX_FETCHED_IN && !tx_w0[D_LAST] |=>
		desc_mem[$past(tx_a0)] == ($past(tx_w0) & 16'h7FFF))
		else $error("middle transmit buffer not freed cleanly");
	tx_heartbeat_a: assert property ( // RULE20
		tx_state_reg == TX_WAIT && TX_DONE_IN && !TX_HEARTBEAT_IN &&
		!ctrl_reg[CTRL_HBOFF_BIT] |=> desc_mem[$past(tx_a0)][TX_HB])
		else $error("heartbeat error not reported");
	tx_starve_a: assert property ( // RULE23
		en && TX_UNDERRUN_IN && !(tx_rel && tx_w0[D_LAST]) |=>
		tx_starve_reg && TX_BAD_CRC_OUT)
		else $error("underrun not recorded");

	rx_last_c: cover property (rx_end ##1 RX_BYTE_VALID_IN);
	tx_frame_c: cover property (
		tx_state_reg == TX_WAIT && TX_DONE_IN);
	tx_discard_c: cover property (
		tx_state_reg == TX_IDLE && tx_rel);
	rx_split_c: cover property (rx_close && !rx_end);

endmodule

/* core/eth_bd_pkg.sv */
package eth_bd_pkg;

	// ----------------------------------------------------------------
	// Register map and bus widths
	// ----------------------------------------------------------------
	localparam int unsigned ADR_W       = 12;
	localparam logic [11:0] CTRL_OFS    = 12'h000;
	localparam logic [11:0] EVENT_OFS   = 12'h004;
	localparam logic [11:0] STATE_OFS   = 12'h008;
	localparam logic [11:0] DESC_OFS    = 12'h400;

	// Control register fields and reset value.
	localparam int unsigned CTRL_ALL_BIT   = 0;
	localparam int unsigned CTRL_TAG_BIT   = 1;
	localparam int unsigned CTRL_HBOFF_BIT = 2;
	localparam int unsigned CTRL_EN_BIT    = 3;
	localparam logic [3:0]  CTRL_RESET     = 4'h0;

	// Event register fields.
	localparam int unsigned EV_RX_BIT = 0;
	localparam int unsigned EV_TX_BIT = 1;

	// State register fields.
	localparam int unsigned ST_TXIDX_LSB = 8;
	localparam int unsigned ST_OPEN_BIT  = 16;
	localparam int unsigned ST_STARVE_BIT = 17;

	// Descriptor word numbers inside one descriptor.
	localparam logic [1:0] W_STAT = 2'h0;
	localparam logic [1:0] W_LEN  = 2'h1;
	localparam logic [1:0] W_PHI  = 2'h2;
	localparam logic [1:0] W_PLO  = 2'h3;

	// Status word bits shared by both tables.
	localparam int unsigned D_OWN  = 15;
	localparam int unsigned D_SW   = 14;
	localparam int unsigned D_WRAP = 13;
	localparam int unsigned D_INT  = 12;
	localparam int unsigned D_LAST = 11;

	// Receive status bits.
	localparam int unsigned RX_FIRST = 10;
	localparam int unsigned RX_MISS  = 8;
	localparam int unsigned RX_LG    = 5;
	localparam int unsigned RX_NO    = 4;
	localparam int unsigned RX_SH    = 3;
	localparam int unsigned RX_CR    = 2;
	localparam int unsigned RX_OV    = 1;
	localparam int unsigned RX_CL    = 0;
	localparam logic [15:0] RX_ERR_MASK = 16'h013F;

	// Transmit status bits.
	localparam int unsigned TX_TC     = 10;
	localparam int unsigned TX_DEF    = 9;
	localparam int unsigned TX_HB     = 8;
	localparam int unsigned TX_LC     = 7;
	localparam int unsigned TX_RL     = 6;
	localparam int unsigned TX_RC_LSB = 2;
	localparam int unsigned TX_UN     = 1;
	localparam int unsigned TX_CSL    = 0;

	// Longest frame that is stored, in bytes.
	localparam logic [10:0] RX_FRAME_MAX = 11'h5F0;

	typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_WAIT} tx_state_type;

endpackage

/* verification/eth_bd_far_end.sv */
`timescale 1ns/1ns
// Frame memory and transmit engine model; it answers slowly on purpose.
module eth_bd_far_end #(
	parameter int unsigned DLY = 5
) (
	input  wire logic        CLK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic        RX_WR_IN,
	input  wire logic        TX_REQ_IN,
	input  wire logic        TX_LAST_IN,
	input  wire logic [31:0] RX_ADDR_IN,
	input  wire logic [7:0]  RX_DATA_IN,
	output logic             TX_FETCHED_OUT,
	output logic             TX_DONE_OUT,
	output logic [15:0]      WR_COUNT_OUT,
	output logic [39:0]      LAST_WR_OUT
);
	logic [7:0] wait_reg;
	logic       pend_reg;
	// The memory counts stored bytes and keeps the last address and byte.
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			WR_COUNT_OUT <= 16'h0000;
			LAST_WR_OUT  <= 40'h00_0000_0000;
		end else if (RX_WR_IN) begin
			WR_COUNT_OUT <= WR_COUNT_OUT + 16'h0001;
			LAST_WR_OUT  <= {RX_DATA_IN, RX_ADDR_IN};
		end
	end
	// Fetch ends late, then the last buffer's outcome arrives later still.
	always_ff @(posedge CLK_IN) begin
		TX_FETCHED_OUT <= 1'b0;
		TX_DONE_OUT <= 1'b0;
		if (!RST_N_IN) begin
			wait_reg <= 8'h00;
			pend_reg <= 1'b0;
		end else if (wait_reg != 8'h00) begin
			wait_reg <= wait_reg - 8'h01;
			if (wait_reg == 8'h01 && !pend_reg) begin
				TX_FETCHED_OUT <= 1'b1;
				pend_reg <= TX_LAST_IN;
				wait_reg <= TX_LAST_IN ? DLY[7:0] : 8'h00;
			end else if (wait_reg == 8'h01) begin
				TX_DONE_OUT <= 1'b1;
				pend_reg <= 1'b0;
			end
		end else if (TX_REQ_IN && !TX_FETCHED_OUT) begin
			wait_reg <= DLY[7:0];
		end
	end
endmodule

/* verification/ethernet_buffer_descriptor_logic_tb_top.sv */
`timescale 1ns/1ns
module ethernet_buffer_descriptor_logic_tb_top;
	import eth_bd_pkg::*;
	logic             clk, rst_n, cyc, stb, we, ack, rx_v, rx_eof, rx_lc;
	logic             rx_odd, rx_crc, rx_ov, rx_m, rx_wr, tx_req, tx_last;
	logic             tx_app, tx_bad, tx_f, tx_d, tx_un, tx_def, tx_col;
	logic             tx_hb, tx_lc, tx_rl, tx_csl;
	logic [ADR_W-1:0] adr;
	logic [3:0]       sel, tx_rc;
	logic [31:0]      wdat, rdat, rx_addr, q;
	logic [7:0]       rx_b, rx_idx, rx_data;
	logic [23:0]      tx_addr;
	logic [15:0]      tx_len, wr_cnt;
	logic [39:0]      last_wr;
	int               mismatches, checked;
	eth_bd_logic #(.TX_DESC(8), .RX_DESC(4), .RX_BUF_MAX(4)) i_dut (
		.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .RX_BYTE_VALID_IN(rx_v),
		.RX_BYTE_IN(rx_b), .RX_EOF_IN(rx_eof), .RX_LATE_COLL_IN(rx_lc),
		.RX_ODD_BITS_IN(rx_odd), .RX_CRC_BAD_IN(rx_crc),
		.RX_OVERRUN_IN(rx_ov), .RX_MATCHED_IN(rx_m),
		.RX_MATCH_INDEX_IN(rx_idx), .RX_WR_OUT(rx_wr),
		.RX_WR_ADDR_OUT(rx_addr), .RX_WR_DATA_OUT(rx_data),
		.TX_REQ_OUT(tx_req), .TX_ADDR_OUT(tx_addr), .TX_LEN_OUT(tx_len),
		.TX_LAST_OUT(tx_last), .TX_APPEND_CRC_OUT(tx_app),
		.TX_BAD_CRC_OUT(tx_bad), .TX_FETCHED_IN(tx_f),
		.TX_UNDERRUN_IN(tx_un), .TX_DONE_IN(tx_d), .TX_DEFERRED_IN(tx_def),
		.TX_COLLIDED_IN(tx_col), .TX_HEARTBEAT_IN(tx_hb),
		.TX_LATE_COLL_IN(tx_lc), .TX_RETRY_LIMIT_IN(tx_rl),
		.TX_RETRIES_IN(tx_rc), .TX_CARRIER_LOST_IN(tx_csl));
	eth_bd_far_end #(.DLY(5)) i_far (.CLK_IN(clk), .RST_N_IN(rst_n),
		.RX_WR_IN(rx_wr), .TX_REQ_IN(tx_req), .TX_LAST_IN(tx_last),
		.RX_ADDR_IN(rx_addr), .RX_DATA_IN(rx_data),
		.TX_FETCHED_OUT(tx_f), .TX_DONE_OUT(tx_d), .WR_COUNT_OUT(wr_cnt),
		.LAST_WR_OUT(last_wr));
	// Free-running system clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Prints the verdict once; a hang is cut short through here too.
	task automatic finish_test();
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
			mismatches++;
		end
	endtask
	// Bounded wait for a level or a one-cycle pulse seen at an edge.
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) begin
			$display("ERROR %0t: wait timed out", $time);
			mismatches++;
			finish_test();
		end
	endtask
	// One classic cycle; the request is held until ack is sampled high.
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [15:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		@(posedge clk);
		wait_hi(ack);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		wb(1'b0, a, 16'h0000);
		chk(q, exp);
	endtask
	function automatic logic [11:0] dsc(input int i, input logic [1:0] w);
		return 12'h400 + 12'(4 * (4 * i + int'(w)));
	endfunction
	// Sends n bytes; frame end comes with the last byte.
	task automatic rx_frame(input int n, input logic crc, input logic ov);
		for (int i = 0; i < n; i++) begin
			rx_v <= 1'b1;
			rx_b <= 8'(i);
			rx_eof <= (i == n - 1);
			rx_crc <= crc;
			rx_ov <= ov;
			@(posedge clk);
		end
		rx_v <= 1'b0;
		rx_eof <= 1'b0;
		rx_ov <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// Six bytes over two four-byte buffers, the second wrapping the table.
	task automatic scen_rx_multi();
		wb(1'b1, dsc(8, W_STAT), 16'h9000);
		wb(1'b1, dsc(8, W_PHI), 16'h0012);
		wb(1'b1, dsc(8, W_PLO), 16'h3400);
		wb(1'b1, dsc(9, W_STAT), 16'hA000);
		wb(1'b1, dsc(9, W_PLO), 16'h7800);
		wb(1'b1, CTRL_OFS, 16'h000B);
		rx_frame(6, 1'b1, 1'b0);
		rdc(dsc(8, W_STAT), 32'h1400);
		rdc(dsc(8, W_LEN), 32'h0004);
		rdc(dsc(8, W_PHI), 32'h5A12);
		rdc(dsc(9, W_STAT), 32'h2904);
		rdc(dsc(9, W_LEN), 32'h0002);
		chk({16'h0000, wr_cnt}, 32'h6);
		chk({last_wr[39:32], last_wr[23:0]}, 32'h05007801);
		rdc(STATE_OFS, 32'h0);
		rdc(EVENT_OFS, 32'h1);
	endtask
	// An overflow frame must leave only the spill flag among the errors.
	task automatic scen_rx_spill();
		wb(1'b1, dsc(8, W_STAT), 16'h9000);
		rx_frame(1, 1'b1, 1'b1);
		rdc(dsc(8, W_STAT), 32'h1C02);
		// Odd bit count with a bad check: partial flag, no checksum flag.
		wb(1'b1, dsc(9, W_STAT), 16'hA000);
		rx_odd <= 1'b1;
		rx_frame(2, 1'b1, 1'b0);
		rdc(dsc(9, W_STAT), 32'h2D10);
	endtask
	// Last buffer with deferred, heartbeat, retry count and carrier flags; pointer high bits must survive.
	task automatic scen_tx();
		wb(1'b1, EVENT_OFS, 16'h0003);
		wb(1'b1, dsc(0, W_LEN), 16'h0010);
		wb(1'b1, dsc(0, W_PHI), 16'hAB12);
		wb(1'b1, dsc(0, W_PLO), 16'h3456);
		wb(1'b1, dsc(0, W_STAT), 16'hDC00);
		wait_hi(tx_req);
		chk({tx_last, tx_app, tx_addr}, 32'h03123456);
		chk({15'h0, tx_bad, tx_len}, 32'h00000010);
		wait_hi(tx_d);
		rdc(dsc(0, W_STAT), 32'h5F15);
		rdc(dsc(0, W_PHI), 32'hAB12);
		rdc(EVENT_OFS, 32'h2);
	endtask
	// Underrun on a middle buffer; the wrapping last one is dumped unsent.
	task automatic scen_tx_starve();
		wb(1'b1, dsc(2, W_STAT), 16'hA800);
		wb(1'b1, dsc(1, W_STAT), 16'hC000);
		wait_hi(tx_req);
		tx_un <= 1'b1;
		@(posedge clk);
		tx_un <= 1'b0;
		@(posedge clk);
		chk({31'h0, tx_bad}, 32'h1);
		wait_hi(tx_f);
		repeat (2) @(posedge clk);
		chk({30'h0, tx_req, tx_bad}, 32'h0);
		rdc(dsc(1, W_STAT), 32'h4000);
		rdc(dsc(2, W_STAT), 32'h2802);
		rdc(STATE_OFS, 32'h0);
	endtask
	// Reset, then the scenarios in turn.
	initial begin
		{rst_n, cyc, stb, we, rx_v, rx_eof, rx_lc, rx_odd, rx_crc} = '0;
		{rx_ov, rx_m, tx_un, tx_col, tx_lc, tx_rl, tx_hb} = '0;
		{adr, wdat, rx_b, mismatches, checked} = '0;
		{sel, rx_idx, tx_def, tx_rc, tx_csl} = {4'h3, 8'h5A, 1'b1, 4'h5, 1'b1};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		scen_rx_multi();
		scen_rx_spill();
		scen_tx();
		scen_tx_starve();
		finish_test();
	end
endmodule
